// >>> core/ocd_pkg.sv
// shared constants and carrier types for the channel six divider configuration block
// assumes a single 100 MHz clock domain and a 16-bit register access port
package ocd_pkg;
    // register indices as seen on the configuration port
    localparam logic [7:0] OCD_ADDR_CTRL = 8'h0F;
    localparam logic [7:0] OCD_ADDR_INTDIV = 8'h10;
    localparam logic [7:0] OCD_ADDR_FRACLO = 8'h11;
    // reset values and writable bit masks (reserved bits held at zero)
    localparam logic [15:0] OCD_CTRL_RESET = 16'h0000;
    localparam logic [15:0] OCD_INTDIV_RESET = 16'h0000;
    localparam logic [15:0] OCD_FRACLO_RESET = 16'h0000;
    localparam logic [15:0] OCD_CTRL_WMASK = 16'h1FDF;
    localparam logic [15:0] OCD_INTDIV_WMASK = 16'h0FFF;
    localparam logic [15:0] OCD_FRACLO_WMASK = 16'hFFFF;
    // control register field positions
    localparam int OCD_PREDIV_LSB = 10;
    localparam int OCD_FRACEN_BIT = 9;
    localparam int OCD_SLEW_BIT = 8;
    localparam int OCD_NEG_BIT = 7;
    localparam int OCD_POS_BIT = 6;
    localparam int OCD_DRV_LSB = 3;
    localparam int OCD_MODE_LSB = 1;
    localparam int OCD_SUPPLY_BIT = 0;
    // integer divider register field positions
    localparam int OCD_INTVAL_LSB = 4;
    localparam int OCD_FRACHI_LSB = 0;
    // pre-divider codes and the matching ratio minus one
    localparam logic [2:0] OCD_PREDIV_DIV2 = 3'h0;
    localparam logic [2:0] OCD_PREDIV_DIV3 = 3'h1;
    localparam logic [2:0] OCD_PREDIV_DIV1 = 3'h7;
    localparam logic [1:0] OCD_RATIO_M1_DIV1 = 2'h0;
    localparam logic [1:0] OCD_RATIO_M1_DIV2 = 2'h1;
    localparam logic [1:0] OCD_RATIO_M1_DIV3 = 2'h2;
    // output mode codes
    localparam logic [1:0] OCD_MODE_OFF = 2'h0;
    localparam logic [1:0] OCD_MODE_CLOCK = 2'h1;
    localparam logic [1:0] OCD_MODE_LOW = 2'h2;
    localparam logic [1:0] OCD_MODE_HIGH = 2'h3;
    // driver type codes
    localparam logic [1:0] OCD_DRV_LVDS_A = 2'h0;
    localparam logic [1:0] OCD_DRV_LVDS_B = 2'h1;
    localparam logic [1:0] OCD_DRV_CMOS = 2'h2;
    localparam logic [1:0] OCD_DRV_HCSL = 2'h3;

    // settings presented to the output driver
    typedef struct packed {
        logic [1:0] driverType;
        logic slewSlow;
        logic posEnable;
        logic negEnable;
        logic supplyHigh;
        logic outEnable;
    } ocd_drive_t;
endpackage

// >>> core/ocd_pulse_div.sv
// small tick divider: passes one of every ratioM1+1 input ticks
// assumes tickIn is a one-cycle enable synchronous to clk
`timescale 1ns/1ps
module ocd_pulse_div import ocd_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic tickIn,
    input wire logic [1:0] ratioM1,
    output logic tickOut
);
    typedef struct packed {
        logic [1:0] cnt;
    } ocd_div_state_t;

    ocd_div_state_t st;
    ocd_div_state_t next_st;

    // >= rather than == so a ratio change mid-count cannot hang the counter
    assign tickOut = tickIn && (st.cnt >= ratioM1);

    // count input ticks, wrap on the passed one
    always_comb begin
        next_st = st;
        if (tickIn) begin
            if (tickOut) begin
                next_st.cnt = 2'h0;
            end else begin
                next_st.cnt = st.cnt + 2'h1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    property p_tick_subset;
        @(posedge clk) disable iff (rst) tickOut |-> tickIn;
    endproperty
    a_tick_subset: assert property (p_tick_subset) else $error("divided tick without input");

    property p_unity_pass;
        @(posedge clk) disable iff (rst) (tickIn && ratioM1 == 2'h0) |-> tickOut;
    endproperty
    a_unity_pass: assert property (p_unity_pass) else $error("unity ratio dropped a tick");

    property p_div2_skip;
        @(posedge clk) disable iff (rst)
            (tickOut && ratioM1 == 2'h1) ##1 (tickIn && ratioM1 == 2'h1) |-> !tickOut;
    endproperty
    a_div2_skip: assert property (p_div2_skip) else $error("divide by two passed twice");
endmodule

// >>> core/ocd_channel.sv
// channel six configuration registers with pre-divider, integer/fractional output divider
// and driver settings; assumes srcTick is the one-cycle enable of the channel source clock
//
// Notes on behaviour
// - Pre-divider code 000 divides by two, 001 by three and 111 passes undivided.
// - With the fractional divider disabled the pre-divider is bypassed whatever its code.
// - Control bit 9 enables the fractional divider when one and disables it when zero.
// - Control bit 8 picks normal edge rate at zero and slow edge rate at one.
// - Bit 6 enables the positive single-ended side, bit 7 the negative side only with it.
// - Driver field 4:3 gives LVDS for 00 and 01, CMOS for 10 and HCSL for 11.
// - Mode field 2:1 gives off, clocking, static low and static high.
// - Control bit 0 selects the 1.8 V range at zero and the 2.5/3.3 V range at one.
// - Integer field 11:4 of the second register divides by its value plus one.
// - The 20-bit fraction is bits 3:0 of the second register over the whole third one.
`timescale 1ns/1ps
module ocd_channel import ocd_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [15:0] regWrData,
    output logic [15:0] regRdData,
    output logic regRdValid,
    input wire logic srcTick,
    output logic chanPulse,
    output logic chanOut,
    output ocd_drive_t drive
);
    typedef struct packed {
        logic [15:0] ctrl;
        logic [15:0] intReg;
        logic [15:0] fracLo;
        logic [15:0] rdData;
        logic rdValid;
        logic [8:0] cnt;
        logic [19:0] acc;
        logic extend;
        logic toggle;
        logic chanPulse;
        logic chanOut;
        ocd_drive_t drive;
    } ocd_chan_state_t;

    ocd_chan_state_t st;
    ocd_chan_state_t next_st;

    logic [2:0] fracPredivSelect;
    logic fracDividerEnable;
    logic singleEndedSlewSelect;
    logic singleEndedNegEnable;
    logic singleEndedPosEnable;
    logic [1:0] driverTypeSelect;
    logic [1:0] channelOutputMode;
    logic supplyRangeSelect;
    logic [7:0] integerDivideValue;
    logic [19:0] fractionalDivideValue;
    logic [1:0] preRatioM1;
    logic divTick;
    logic preTick;
    logic [8:0] limit;
    logic [20:0] accSum;

    // field views of the stored registers
    assign fracPredivSelect = st.ctrl[OCD_PREDIV_LSB +: 3];
    assign fracDividerEnable = st.ctrl[OCD_FRACEN_BIT];
    assign singleEndedSlewSelect = st.ctrl[OCD_SLEW_BIT];
    assign singleEndedNegEnable = st.ctrl[OCD_NEG_BIT];
    assign singleEndedPosEnable = st.ctrl[OCD_POS_BIT];
    assign driverTypeSelect = st.ctrl[OCD_DRV_LSB +: 2];
    assign channelOutputMode = st.ctrl[OCD_MODE_LSB +: 2];
    assign supplyRangeSelect = st.ctrl[OCD_SUPPLY_BIT];
    assign integerDivideValue = st.intReg[OCD_INTVAL_LSB +: 8];
    assign fractionalDivideValue = {st.intReg[OCD_FRACHI_LSB +: 4], st.fracLo};

    // pre-divider ratio; reserved codes fall back to divide by two rather than stall
    always_comb begin
        case (fracPredivSelect)
            OCD_PREDIV_DIV2: preRatioM1 = OCD_RATIO_M1_DIV2;
            OCD_PREDIV_DIV3: preRatioM1 = OCD_RATIO_M1_DIV3;
            OCD_PREDIV_DIV1: preRatioM1 = OCD_RATIO_M1_DIV1;
            default: preRatioM1 = OCD_RATIO_M1_DIV2;
        endcase
    end

    ocd_pulse_div u_prediv (
        .clk(clk),
        .rst(rst),
        .tickIn(srcTick && fracDividerEnable),
        .ratioM1(preRatioM1),
        .tickOut(divTick)
    );

    // pre-divider only sits in the path while the fractional divider runs
    assign preTick = fracDividerEnable ? divTick : srcTick;

    // period is limit+1 ticks; a fractional carry stretches one period by a tick
    assign limit = {1'b0, integerDivideValue} + {8'h00, st.extend};
    assign accSum = {1'b0, st.acc} + {1'b0, fractionalDivideValue};

    always_comb begin
        next_st = st;
        next_st.rdValid = 1'b0;
        next_st.chanPulse = 1'b0;

        // register writes; reserved bits are not stored and read back as zero
        if (regWrite) begin
            case (regAddr)
                OCD_ADDR_CTRL: next_st.ctrl = regWrData & OCD_CTRL_WMASK;
                OCD_ADDR_INTDIV: next_st.intReg = regWrData & OCD_INTDIV_WMASK;
                OCD_ADDR_FRACLO: next_st.fracLo = regWrData & OCD_FRACLO_WMASK;
                default: ;
            endcase
        end

        // reads answer one cycle later; unmapped indices return zero
        if (regRead) begin
            next_st.rdValid = 1'b1;
            case (regAddr)
                OCD_ADDR_CTRL: next_st.rdData = st.ctrl;
                OCD_ADDR_INTDIV: next_st.rdData = st.intReg;
                OCD_ADDR_FRACLO: next_st.rdData = st.fracLo;
                default: next_st.rdData = 16'h0000;
            endcase
        end

        // output divider driven by the (possibly pre-divided) source tick
        if (preTick) begin
            if (st.cnt >= limit) begin
                next_st.cnt = 9'h000;
                next_st.chanPulse = 1'b1;
                next_st.toggle = ~st.toggle;
                if (fracDividerEnable) begin
                    next_st.acc = accSum[19:0];
                    next_st.extend = accSum[20];
                end else begin
                    next_st.extend = 1'b0;
                end
            end else begin
                next_st.cnt = st.cnt + 9'h001;
            end
        end
        if (!fracDividerEnable) begin
            next_st.extend = 1'b0;
        end

        // output level per mode
        case (channelOutputMode)
            OCD_MODE_CLOCK: next_st.chanOut = next_st.toggle;
            OCD_MODE_HIGH: next_st.chanOut = 1'b1;
            default: next_st.chanOut = 1'b0;
        endcase

        // driver settings; the negative side is masked unless the positive side is on
        next_st.drive.driverType = driverTypeSelect;
        next_st.drive.slewSlow = singleEndedSlewSelect;
        next_st.drive.posEnable = singleEndedPosEnable;
        next_st.drive.negEnable = singleEndedNegEnable && singleEndedPosEnable;
        next_st.drive.supplyHigh = supplyRangeSelect;
        next_st.drive.outEnable = (channelOutputMode != OCD_MODE_OFF);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.ctrl <= OCD_CTRL_RESET;
            st.intReg <= OCD_INTDIV_RESET;
            st.fracLo <= OCD_FRACLO_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign regRdData = st.rdData;
    assign regRdValid = st.rdValid;
    assign chanPulse = st.chanPulse;
    assign chanOut = st.chanOut;
    assign drive = st.drive;

    // a control write followed by two write-free settling cycles
    sequence s_ctrl_write;
        regWrite && regAddr == OCD_ADDR_CTRL ##1 !regWrite ##1 !regWrite;
    endsequence

    property p_prediv_code;
        @(posedge clk) disable iff (rst)
            fracPredivSelect == OCD_PREDIV_DIV3 |-> preRatioM1 == OCD_RATIO_M1_DIV3;
    endproperty
    a_prediv_code: assert property (p_prediv_code) else $error("pre-divide code mismatch");

    property p_bypass;
        @(posedge clk) disable iff (rst) !fracDividerEnable |-> (preTick == srcTick);
    endproperty
    a_bypass: assert property (p_bypass) else $error("pre-divider not bypassed");

    property p_frac_enable;
        @(posedge clk) disable iff (rst)
            (fracDividerEnable && fracPredivSelect == OCD_PREDIV_DIV2 && preTick)
                |-> !$past(preTick) || !$past(fracDividerEnable);
    endproperty
    a_frac_enable: assert property (p_frac_enable) else $error("enable bit ignored");

    property p_slew;
        @(posedge clk) disable iff (rst)
            s_ctrl_write |-> drive.slewSlow == $past(regWrData[OCD_SLEW_BIT], 2);
    endproperty
    a_slew: assert property (p_slew) else $error("slew select not applied");

    property p_neg_gate;
        @(posedge clk) disable iff (rst) drive.negEnable |-> drive.posEnable;
    endproperty
    a_neg_gate: assert property (p_neg_gate) else $error("negative side without positive");

    property p_drv_type;
        @(posedge clk) disable iff (rst)
            s_ctrl_write |-> drive.driverType == $past(regWrData[OCD_DRV_LSB +: 2], 2);
    endproperty
    a_drv_type: assert property (p_drv_type) else $error("driver type not applied");

    property p_static_high;
        @(posedge clk) disable iff (rst)
            $past(channelOutputMode) == OCD_MODE_HIGH |-> chanOut && drive.outEnable;
    endproperty
    a_static_high: assert property (p_static_high) else $error("static high not held");

    property p_supply;
        @(posedge clk) disable iff (rst)
            s_ctrl_write |-> drive.supplyHigh == $past(regWrData[OCD_SUPPLY_BIT], 2);
    endproperty
    a_supply: assert property (p_supply) else $error("supply range not applied");

    property p_int_period;
        @(posedge clk) disable iff (rst)
            chanPulse |-> $past(st.cnt) >= {1'b0, $past(integerDivideValue)};
    endproperty
    a_int_period: assert property (p_int_period) else $error("output period too short");

    property p_frac_accum;
        @(posedge clk) disable iff (rst)
            (chanPulse && $past(fracDividerEnable))
                |-> st.acc == $past(st.acc) + $past(fractionalDivideValue);
    endproperty
    a_frac_accum: assert property (p_frac_accum) else $error("fraction not accumulated");

    property p_int_only;
        @(posedge clk) disable iff (rst)
            (!fracDividerEnable && $past(!fracDividerEnable)) |-> $stable(st.acc) && !st.extend;
    endproperty
    a_int_only: assert property (p_int_only) else $error("fraction active while disabled");

    // an integer-register write with no write right behind it
    sequence s_int_write;
        regWrite && regAddr == OCD_ADDR_INTDIV ##1 !regWrite;
    endsequence

    property p_int_store;
        @(posedge clk) disable iff (rst)
            s_int_write |-> integerDivideValue == $past(regWrData[OCD_INTVAL_LSB +: 8]);
    endproperty
    a_int_store: assert property (p_int_store) else $error("integer value not stored");

    property p_frac_hi_store;
        @(posedge clk) disable iff (rst)
            s_int_write
                |-> fractionalDivideValue[19:16] == $past(regWrData[OCD_FRACHI_LSB +: 4]);
    endproperty
    a_frac_hi_store: assert property (p_frac_hi_store) else $error("high fraction lost");

    property p_frac_lo_store;
        @(posedge clk) disable iff (rst)
            (regWrite && regAddr == OCD_ADDR_FRACLO)
                |=> fractionalDivideValue[15:0] == $past(regWrData);
    endproperty
    a_frac_lo_store: assert property (p_frac_lo_store) else $error("low fraction lost");

    property p_static_low;
        @(posedge clk) disable iff (rst)
            $past(channelOutputMode) == OCD_MODE_LOW |-> !chanOut && drive.outEnable;
    endproperty
    a_static_low: assert property (p_static_low) else $error("static low not held");

    // disabled output stays quiet and its driver released
    property p_mode_off;
        @(posedge clk) disable iff (rst)
            $past(channelOutputMode) == OCD_MODE_OFF |-> !chanOut && !drive.outEnable;
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("disabled output active");

    // two cycles of clocking mode ahead of a period end
    sequence s_clock_mode;
        (channelOutputMode == OCD_MODE_CLOCK) [*2];
    endsequence

    property p_clock_toggle;
        @(posedge clk) disable iff (rst)
            s_clock_mode ##1 chanPulse |-> chanOut != $past(chanOut);
    endproperty
    a_clock_toggle: assert property (p_clock_toggle) else $error("output did not toggle");

    // undivided code leaves every source tick in place
    property p_prediv_unity;
        @(posedge clk) disable iff (rst)
            (fracDividerEnable && fracPredivSelect == OCD_PREDIV_DIV1)
                |-> preTick == srcTick;
    endproperty
    a_prediv_unity: assert property (p_prediv_unity) else $error("undivided code divided");

    // source ticks seen by the pre-divider while it divides by three
    sequence s_div3_ticks;
        (srcTick && fracDividerEnable && fracPredivSelect == OCD_PREDIV_DIV3) [*2];
    endsequence

    property p_div3_gap;
        @(posedge clk) disable iff (rst)
            (divTick && fracPredivSelect == OCD_PREDIV_DIV3) ##1 s_div3_ticks
                |-> !divTick && !$past(divTick);
    endproperty
    a_div3_gap: assert property (p_div3_gap) else $error("divide by three too fast");
endmodule

// >>> bench/ocd_host_model.sv
// host model: configuring software on the register port of channel six
// assumes the channel takes strobes on the rising edge of clk
`timescale 1ns/1ps
module ocd_host_model import ocd_pkg::*; (
    input wire logic clk,
    output logic regWrite,
    output logic regRead,
    output logic [7:0] regAddr,
    output logic [15:0] regWrData
);
    initial begin
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 8'h00;
        regWrData = 16'h0000;
    end

    // writes clean data; models a slow-vco part, so the undivided code is allowed
    task automatic wr(input logic [7:0] a, input logic [15:0] d, output logic [15:0] v);
        v = d;
        if (a == OCD_ADDR_CTRL) begin
            v[15:13] = 3'h0;
            v[5] = 1'b0;
            if (v[12:10] != OCD_PREDIV_DIV3 && v[12:10] != OCD_PREDIV_DIV1) begin
                v[12:10] = OCD_PREDIV_DIV2;
            end
            if (!v[6]) begin
                v[7] = 1'b0;
            end
        end
        if (a == OCD_ADDR_INTDIV) begin
            v[15:12] = 4'h0;
        end
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= v;
        @(posedge clk);
        regWrite <= 1'b0;
        regWrData <= ~v; // released data must not linger
    endtask

    // one-cycle read strobe, address scrambled once released
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        regAddr <= ~a;
    endtask
endmodule

// >>> bench/output_channel_six_divider_config_tb.sv
// self-checking bench for the channel six configuration block
// assumes ocd_host_model drives the register port; reads checked through a queue
`timescale 1ns/1ps
module output_channel_six_divider_config_tb import ocd_pkg::*; ;
    logic clk, rst, srcTick, regWrite, regRead, regRdValid, chanPulse, chanOut;
    logic [7:0] regAddr;
    logic [15:0] regWrData, regRdData, sent, d;
    ocd_drive_t drive;
    logic [15:0] expQ[$];
    int n_fail, cmp_count, n;
    // last entry: fraction carry on every period stretches it by one pre-divided tick
    logic [15:0] ctrlT[6] = '{16'h0402, 16'h0202, 16'h0602, 16'h1E02, 16'h0002, 16'h0202};
    logic [15:0] intT[6] = '{16'h003A, 16'h0030, 16'h0030, 16'h0030, 16'h0FF0, 16'h003F};
    logic [15:0] frT[6] = '{16'hFFFF, 16'h0000, 16'h0000, 16'h0000, 16'h1234, 16'hFFFF};
    logic [15:0] expT[6] = '{16'h0004, 16'h0008, 16'h000C, 16'h0004, 16'h0100, 16'h000A};

    ocd_channel u_dut (.clk(clk), .rst(rst), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
        .regRdValid(regRdValid), .srcTick(srcTick), .chanPulse(chanPulse),
        .chanOut(chanOut), .drive(drive));
    ocd_host_model u_host (.clk(clk), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWrData(regWrData));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // note the answer first, then issue the read
    task automatic rdx(input logic [7:0] a, input logic [15:0] e);
        expQ.push_back(e);
        u_host.rd(a);
    endtask

    function automatic ocd_drive_t mkDrive(input logic [15:0] v);
        return {v[4:3], v[8], v[6], v[7] & v[6], v[0], v[2:1] != 2'h0};
    endfunction

    // cycles between two pulses; the first pulse after a change may be partial
    task automatic period(output int p);
        int k;
        k = 0;
        while (chanPulse !== 1'b1 && k < 3000) begin
            @(negedge clk);
            k++;
        end
        @(negedge clk);
        p = 1;
        while (chanPulse !== 1'b1 && p < 3000) begin
            @(negedge clk);
            p++;
        end
    endtask

    // read answers are one-cycle pulses, so look at every cycle
    always @(negedge clk) begin
        if (regRdValid === 1'b1 && expQ.size() == 0) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, regRdData, 16'h0000);
        end else if (regRdValid === 1'b1) begin
            chk(regRdData, expQ.pop_front());
        end
    end

    task automatic close_out;
        $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // cut a hang short well past the expected run length
    initial begin
        #300us;
        n_fail++;
        close_out();
    end

    initial begin
        void'($urandom(32'hADECC9CB));
        n_fail = 0;
        cmp_count = 0;
        rst = 1'b1;
        srcTick = 1'b0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        // reset values and an unmapped index
        rdx(OCD_ADDR_CTRL, 16'h0000);
        rdx(OCD_ADDR_INTDIV, 16'h0000);
        rdx(OCD_ADDR_FRACLO, 16'h0000);
        rdx(8'h12, 16'h0000);
        // every driver type and mode code with random other fields
        for (int i = 0; i < 16; i++) begin
            d = 16'($urandom);
            d[4:1] = i[3:0];
            u_host.wr(OCD_ADDR_CTRL, d, sent);
            rdx(OCD_ADDR_CTRL, sent & OCD_CTRL_WMASK);
            @(negedge clk);
            chk({9'h000, drive}, {9'h000, mkDrive(sent)});
            // with no source ticks only the clocking mode may keep a stale level
            if (i[1:0] != 2'h1) begin
                chk({15'h0000, chanOut}, {15'h0000, i[1] & i[0]});
            end
            u_host.wr(OCD_ADDR_INTDIV, 16'($urandom), sent);
            rdx(OCD_ADDR_INTDIV, sent & OCD_INTDIV_WMASK);
            u_host.wr(OCD_ADDR_FRACLO, 16'($urandom), sent);
            rdx(OCD_ADDR_FRACLO, sent);
        end
        // divide ratios: prescaler codes, bypass and integer boundary
        srcTick <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            u_host.wr(OCD_ADDR_INTDIV, intT[k], sent);
            u_host.wr(OCD_ADDR_FRACLO, frT[k], sent);
            u_host.wr(OCD_ADDR_CTRL, ctrlT[k], sent);
            // third period lies past any carry pending from the switch
            period(n);
            period(n);
            period(n);
            chk(16'(n), expT[k]);
        end
        repeat (4) @(posedge clk);
        if (expQ.size() != 0) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, expQ.size(), 0);
        end
        close_out();
    end
endmodule
